// ---- bcs_top.sv ----
/*
 bcs_top: boot cluster swap remap between instruction fetch and flash.
 assumes firmware drives SWAP_NV from the nonvolatile swap setting.
*/
// Notes on behaviour
// - two 4 KB clusters exchanged whole
// - cluster 0 is 0000H to 0FFFH
// - cluster 1 is 1000H to 1FFFH
// - recorded swap makes cluster 1 boot
// - swap setting persists; reset boots cluster 1
// - clearing setting restores original arrangement at next reset
// - flag and ID bytes follow the swap
`timescale 1ns/1ps
module bcs_top
    import bcs_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // nonvolatile swap setting
    input wire logic SWAP_NV,
    // fetch side
    input wire logic [BCS_ADDR_W-1:0] FETCH_ADDR,
    // flash side
    output logic [BCS_ADDR_W-1:0] FLASH_ADDR,
    output logic SWAP_ACTIVE
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
            rst_sync_reg <= BCS_SYNC_RST;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // ----------------------------------------
    // swap sampling
    // ----------------------------------------
    // setting is a pin from flash, so pass two flops first
    logic [1:0] nv_sync_reg;
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
            nv_sync_reg <= BCS_SYNC_RST;
        else
            nv_sync_reg <= {nv_sync_reg[0], SWAP_NV};
    end

    // settle flag: the synchroniser restarts with the internal reset, so two
    // edges must pass before its output is a sample of the pin and not its
    // reset value; taking it earlier would always boot unswapped
    logic [1:0] settle_reg;
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
            settle_reg <= BCS_SYNC_RST;
        else
            settle_reg <= {settle_reg[0], 1'b1};
    end

    // latch once after the synchroniser has settled; later changes of the
    // setting wait for the next reset, so a fetch never sees the map move
    // under it while a program runs from either cluster
    logic swap_reg;
    logic taken_reg;
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            swap_reg <= BCS_SWAP_RST;
            taken_reg <= 1'b0;
        end
        else if (!taken_reg && settle_reg[1])
        begin
            taken_reg <= 1'b1;
            swap_reg <= nv_sync_reg[1];
        end
    end
    // the flag shows which arrangement this run boots from
    assign SWAP_ACTIVE = swap_reg;

    // ----------------------------------------
    // address remap
    // ----------------------------------------
    logic [BCS_ADDR_W-1:0] mapped;
    bcs_remap u_remap (
        .swap(swap_reg),
        .addr_in(FETCH_ADDR),
        .addr_out(mapped)
    );
    // cluster ranges: 0000H-0FFFH and 1000H-1FFFH trade places
    assign FLASH_ADDR = mapped;

    // ----------------------------------------
    // checks on the remap
    // ----------------------------------------
    // the checks are off while the internal reset is low; the map is then
    // plain by design, and the sample flops still hold their reset values

    // cluster decode shared by the checks below
    function automatic logic in_c0(input logic [BCS_ADDR_W-1:0] a);
        return a <= BCS_C0_LAST;
    endfunction

    function automatic logic in_c1(input logic [BCS_ADDR_W-1:0] a);
        return (a >= BCS_C1_BASE) && (a <= BCS_C1_LAST);
    endfunction

    // flag byte and id bytes of the cluster whose base is given
    function automatic logic in_id(
        input logic [BCS_ADDR_W-1:0] a,
        input logic [BCS_ADDR_W-1:0] base
    );
        return (a >= (BCS_DBG_FLAG | base)) && (a <= (BCS_SEC_ID_LAST | base));
    endfunction

    // a recorded swap puts cluster 1 where cluster 0 was
    a_c0_to_c1: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (swap_reg && in_c0(FETCH_ADDR)) |->
        (FLASH_ADDR == FETCH_ADDR + BCS_C1_BASE))
        else $error("cluster 0 not mapped to cluster 1");

    // and cluster 0 where cluster 1 was
    a_c1_to_c0: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (swap_reg && in_c1(FETCH_ADDR)) |->
        (FLASH_ADDR == FETCH_ADDR - BCS_C1_BASE))
        else $error("cluster 1 not mapped to cluster 0");

    // with the setting clear every address goes through untouched
    a_no_swap_id: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        !swap_reg |-> (FLASH_ADDR == FETCH_ADDR))
        else $error("address changed without swap");

    // an unswapped run takes its boot vector from cluster 0
    a_boot_c0: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (!swap_reg && (FETCH_ADDR == BCS_C0_BASE)) |-> (FLASH_ADDR == BCS_C0_BASE))
        else $error("boot vector not from cluster 0");

    // a swapped run takes its boot vector from cluster 1
    a_boot_c1: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (swap_reg && (FETCH_ADDR == BCS_C0_BASE)) |-> (FLASH_ADDR == BCS_C1_BASE))
        else $error("boot vector not from cluster 1");

    // flag and id bytes at the boot position are read from cluster 1
    a_id_bytes: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (swap_reg && in_id(FETCH_ADDR, BCS_C0_BASE)) |->
        FLASH_ADDR[BCS_CLUSTER_BIT])
        else $error("id byte not from cluster 1");

    // and their copies in cluster 1 are read from cluster 0
    a_id_back: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (swap_reg && in_id(FETCH_ADDR, BCS_C1_BASE)) |->
        !FLASH_ADDR[BCS_CLUSTER_BIT])
        else $error("id byte copy not from cluster 0");

    // addresses above the two clusters are never moved
    a_high_flat: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (FETCH_ADDR > BCS_C1_LAST) |-> (FLASH_ADDR == FETCH_ADDR))
        else $error("address above boot region remapped");

    // the offset inside a cluster is kept, so clusters move as whole units
    a_offset_kept: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (FETCH_ADDR <= BCS_C1_LAST) |->
        (FLASH_ADDR[BCS_CLUSTER_BIT-1:0] == FETCH_ADDR[BCS_CLUSTER_BIT-1:0]))
        else $error("offset inside cluster changed");

    // a boot address never leaves the two clusters
    a_boot_stay: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (FETCH_ADDR <= BCS_C1_LAST) |-> (FLASH_ADDR <= BCS_C1_LAST))
        else $error("boot address left the boot region");

    // ----------------------------------------
    // checks on the sample
    // ----------------------------------------
    // step one: the internal reset has just let go
    sequence s_released;
        $rose(rst_n);
    endsequence

    // step two: two edges pass while the synchroniser fills
    sequence s_settling;
        !taken_reg ##1 !taken_reg;
    endsequence

    // step three: the setting now stands in the swap flop
    sequence s_taken;
        taken_reg && (swap_reg == $past(nv_sync_reg[1]));
    endsequence

    // step four: one edge later the mapping has not moved, whatever the pin does
    sequence s_held;
        taken_reg && $stable(swap_reg);
    endsequence

    // the whole sample, from release of the internal reset to the held map
    a_take_once: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (s_released ##1 s_settling) |=> (s_taken ##1 s_held))
        else $error("swap setting not taken at the right edge");

    // no swapped mapping before the setting has been taken
    a_early_plain: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        !taken_reg |-> !swap_reg)
        else $error("swap in force before the sample");

    // the sample is taken once per reset
    a_taken_keep: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        taken_reg |=> taken_reg)
        else $error("sample flag dropped during run");

    // once taken, the mapping does not change until the next reset
    a_swap_hold: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        taken_reg |=> $stable(swap_reg))
        else $error("mapping changed during run");

    // the stored setting is what the synchroniser held at the sample edge
    a_swap_take: assert property (
        @(posedge REF_CLK) disable iff (!rst_n)
        (!taken_reg && settle_reg[1]) |=> (swap_reg == $past(nv_sync_reg[1])))
        else $error("swap setting not sampled");
endmodule // bcs_top

// ---- bcs_pkg.sv ----
/*
 boot cluster swap package: address layout, cluster size, reset values of the swap and sync flops.
 assumes a 16-bit fetch address space with flash starting at address zero.
*/
package bcs_pkg;
    // ----------------------------------------
    // address layout
    // ----------------------------------------
    localparam int BCS_ADDR_W = 16;
    localparam int BCS_CLUSTER_BYTES = 4096;
    localparam int BCS_CLUSTER_BIT = 12;
    localparam logic [15:0] BCS_C0_BASE = 16'h0000;
    localparam logic [15:0] BCS_C0_LAST = 16'h0FFF;
    localparam logic [15:0] BCS_C1_BASE = 16'h1000;
    localparam logic [15:0] BCS_C1_LAST = 16'h1FFF;
    localparam logic [15:0] BCS_DBG_FLAG = 16'h0084;
    localparam logic [15:0] BCS_SEC_ID_LAST = 16'h008E;
    localparam logic BCS_SWAP_RST = 1'b0;
    localparam logic [1:0] BCS_SYNC_RST = 2'b00;
endpackage

// ---- bcs_remap.sv ----
/*
 bcs_remap: combinational address exchange of boot clusters 0 and 1.
 assumes the swap level is already stable for the whole run.
*/
`timescale 1ns/1ps
module bcs_remap
    import bcs_pkg::*;
(
    // control
    input wire logic swap,
    // address
    input wire logic [BCS_ADDR_W-1:0] addr_in,
    output logic [BCS_ADDR_W-1:0] addr_out
);
    // flipping bit 12 inside the low 8 KB swaps both clusters whole
    logic in_boot;
    assign in_boot = (addr_in <= BCS_C1_LAST);
    assign addr_out = (swap && in_boot) ?
        (addr_in ^ BCS_C1_BASE) : addr_in;
endmodule // bcs_remap

// ---- bcs_top_tb_top.sv ----
/*
 bcs_top_tb_top: self-checking bench for the boot cluster swap remap.
 assumes bcs_pkg and bcs_top are compiled ahead of this file.
*/
`timescale 1ns/1ps
module bcs_top_tb_top
    import bcs_pkg::*;
;
    // ----------------------------------------
    // stimulus and probes
    // ----------------------------------------
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic swap_nv = 1'b0;
    logic [15:0] fetch_addr = 16'h0000;
    logic [15:0] flash_addr;
    logic swap_active;
    int errors = 0;
    int comparisons = 0;
    // cluster edges, flag byte, id bytes, and addresses above the boot region
    logic [15:0] probe [9] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h0084,
                               16'h1084, 16'h008E, 16'h2000, 16'hFFFF};
    bcs_top dut_u (.REF_CLK(ref_clk), .RST_B(rst_b), .SWAP_NV(swap_nv),
                   .FETCH_ADDR(fetch_addr), .FLASH_ADDR(flash_addr), .SWAP_ACTIVE(swap_active));
    // 100 MHz clock
    initial forever #5 ref_clk = ~ref_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    // reset is held 8 cycles; the setting must stay put until the sample lands
    task automatic do_reset(input logic sw);
        @(negedge ref_clk);
        rst_b = 1'b0;
        swap_nv = sw;
        @(negedge ref_clk);
        check({15'h0000, swap_active}, 16'h0000);
        repeat (7) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask
    // addresses change on the falling edge so the lookup is settled when compared;
    // expected places follow the cluster layout, not the remap's own expression
    task automatic check_map(input logic sw);
        for (int i = 0; i < 9; i++)
        begin
            @(negedge ref_clk);
            fetch_addr = probe[i];
            #1;
            if (probe[i] <= BCS_C0_LAST)
                check(flash_addr, sw ? probe[i] + BCS_C1_BASE : probe[i]);
            else if (probe[i] <= BCS_C1_LAST)
                check(flash_addr, sw ? probe[i] - BCS_C1_BASE : probe[i]);
            else
                check(flash_addr, probe[i]);
        end
        check({15'h0000, swap_active}, {15'h0000, sw});
    endtask
    task automatic t_plain();
        do_reset(1'b0);
        check_map(1'b0);
    endtask
    // cluster 1 counts as written and verified before the setting is raised;
    // a second reset with the setting still recorded must boot swapped again
    task automatic t_swap_hold();
        do_reset(1'b1);
        check_map(1'b1);
        @(negedge ref_clk);
        swap_nv = 1'b0;
        repeat (4) @(negedge ref_clk);
        check_map(1'b1);
        do_reset(1'b1);
        check_map(1'b1);
    endtask
    task automatic t_restore();
        do_reset(1'b0);
        check_map(1'b0);
        @(negedge ref_clk);
        swap_nv = 1'b1;
        repeat (4) @(negedge ref_clk);
        check_map(1'b0);
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        t_plain();
        t_swap_hold();
        t_restore();
        report_and_stop();
    end
    // watchdog: the tests need about 125 cycles, so 5000 means a hang
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        report_and_stop();
    end
endmodule // bcs_top_tb_top
